// ### core/pss_array.sv
// storage array with registered read data and per-lane write masking
`timescale 1ns/1ps
module pss_array #(
    parameter int ADDR_W = 18,
    parameter int LANES = 4,
    parameter int LANE_W = 9
) (
    input wire logic clk_in,
    input wire logic rd_en_in,
    input wire logic [ADDR_W-1:0] rd_addr_in,
    output logic [LANES*LANE_W-1:0] rd_data_out,
    input wire logic wr_en_in,
    input wire logic [ADDR_W-1:0] wr_addr_in,
    input wire logic [LANES-1:0] wr_lane_in,
    input wire logic [LANES*LANE_W-1:0] wr_data_in
);
    import pss_pkg::*;

    logic [LANES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [LANES*LANE_W-1:0] merged;

    // a read on the same edge as a write to the same word sees the new lanes
    always_comb begin
        merged = mem[wr_addr_in];
        for (int i = 0; i < LANES; i++) begin
            if (wr_lane_in[i]) begin
                merged[i*LANE_W +: LANE_W] = wr_data_in[i*LANE_W +: LANE_W];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= merged;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rd_en_in) begin
            if (wr_en_in && wr_addr_in == rd_addr_in) begin
                rd_data_out <= merged;
            end else begin
                rd_data_out <= mem[rd_addr_in];
            end
        end
    end
endmodule

// ### core/pss_defs.svh
// constants for the pipelined synchronous static memory port
// Notes on behaviour
// - address bits, low two included, are registered on the rising clock edge
// - one active-low write enable per byte lane; only enabled lanes are written
// - 18-bit has two lanes, 32/36-bit has four; each gates a byte plus its parity bit where present
// - parity bits exist only in 18-bit and 36-bit organisations
// - clock enable high freezes all state except the snooze synchronizer; edges act only when it is low
// - read/write select sets the cycle type only on load edges
// - a read stays a read, a write a write, until a new address load
// - a write with all lane enables low writes the whole bus, parity included
// - address, chip enables, lane enables and burst control register together; write data follows two edges later
// - first active-low chip enable is sampled only at an address load
// - second active-low chip enable is sampled only at an address load
// - active-high chip enable sampled at load; all three needed to select
// - snooze input high enters standby and keeps the array contents
// - while snooze is high every other input is ignored; the code lags snooze by four edges each way and srst_in still acts
// - advance/load low loads an address; high advances the burst counter
// - order select low means linear, high interleaved; held constant
// - active-low output enable gates the data drivers without touching the pipeline
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH
`define PSS_ADDR_W_DEF 18
`define PSS_ADDR_W_MAX 20
`define PSS_LANES_DEF 4
`define PSS_PARITY_DEF 1
`define PSS_BYTE_W 8
`define PSS_BURST_W 2
`define PSS_READ_LATENCY 2
`endif

// ### core/pss_pkg.sv
// types shared by the memory port and its array
package pss_pkg;
    typedef enum logic {
        PSS_ORDER_LINEAR,
        PSS_ORDER_INTERLEAVED
    } pss_order_t;

    // pipeline slot control, carried stage to stage with its address and lanes
    typedef struct packed {
        logic valid;
        logic write;
    } pss_ctl_t;
endpackage

// ### core/pss_port.sv
// pipelined synchronous memory port: command pipeline, burst counter, snooze, data bus
`timescale 1ns/1ps
`include "pss_defs.svh"
module pss_port #(
    parameter int ADDR_W = `PSS_ADDR_W_DEF,
    parameter int LANES = `PSS_LANES_DEF,
    parameter int PARITY = `PSS_PARITY_DEF
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic clock_enable_n_in,
    input wire logic advance_or_load_in,
    input wire logic rw_select_in,
    input wire logic select_low_first_n_in,
    input wire logic select_low_second_n_in,
    input wire logic select_high_in,
    input wire logic address_bit_zero_in,
    input wire logic address_bit_one_in,
    input wire logic [ADDR_W-3:0] upper_address_bus_in,
    input wire logic [LANES-1:0] lane_write_n_in,
    input wire logic linear_order_n_in,
    input wire logic output_enable_n_in,
    input wire logic sleep_request_in,
    input wire logic [LANES*(`PSS_BYTE_W+PARITY)-1:0] data_lane_in,
    output logic [LANES*(`PSS_BYTE_W+PARITY)-1:0] data_lane_out,
    output logic data_lane_oe_out,
    output logic asleep_out
);
    import pss_pkg::*;

    localparam int LANE_W = `PSS_BYTE_W + PARITY;
    localparam int DATA_W = LANES * LANE_W;
    localparam int BW = `PSS_BURST_W;

    // 18-bit needs two lanes, 32/36-bit four; parity is present or absent per lane
    generate
        if (!(LANES == 2 || LANES == 4) || PARITY < 0 || PARITY > 1 ||
            ADDR_W < 3 || ADDR_W > `PSS_ADDR_W_MAX) begin : g_bad_params
            $error("pss_port: unsupported organisation parameters");
        end
    endgenerate

    // low address of a burst beat: linear adds the count, interleaved xors it
    function automatic logic [BW-1:0] beat_low(input logic [BW-1:0] base,
                                               input logic [BW-1:0] count,
                                               input pss_order_t order);
        logic [BW-1:0] sum;
        sum = base + count;
        if (order == PSS_ORDER_INTERLEAVED) begin
            beat_low = base ^ count;
        end else begin
            beat_low = sum;
        end
    endfunction

    // snooze is asynchronous, so it runs through three flops before use
    logic sleep_s1;
    logic sleep_s2;
    logic sleep_s3;
    logic asleep;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sleep_s1 <= 1'b0;
            sleep_s2 <= 1'b0;
            sleep_s3 <= 1'b0;
        end else begin
            sleep_s1 <= sleep_request_in;
            sleep_s2 <= sleep_s1;
            sleep_s3 <= sleep_s2;
        end
    end

    // a level counts only once the last two stages agree
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            asleep <= 1'b0;
        end else if (sleep_s2 == sleep_s3) begin
            asleep <= sleep_s3;
        end
    end

    assign asleep_out = asleep;

    logic step;
    logic load;
    logic advance;
    logic selected;
    pss_order_t order;
    logic [ADDR_W-1:0] ext_addr;

    // an edge acts only with clock enable low and the port awake
    assign step = !clock_enable_n_in && !asleep;
    assign load = step && !advance_or_load_in;
    assign advance = step && advance_or_load_in;
    assign selected = !select_low_first_n_in && !select_low_second_n_in &&
                      select_high_in;
    assign order = linear_order_n_in ? PSS_ORDER_INTERLEAVED : PSS_ORDER_LINEAR;
    assign ext_addr = {upper_address_bus_in, address_bit_one_in, address_bit_zero_in};

    // burst context held from the last load
    pss_ctl_t burst_ctl;
    logic [ADDR_W-1:0] burst_base;
    logic [BW-1:0] burst_count;
    logic [BW-1:0] next_count;

    assign next_count = burst_count + 1'b1;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            burst_ctl <= '0;
            burst_base <= '0;
            burst_count <= '0;
        end else if (load) begin
            burst_ctl.valid <= selected;
            burst_ctl.write <= !rw_select_in;
            burst_base <= ext_addr;
            burst_count <= '0;
        end else if (advance) begin
            // chip enables and read/write select are not looked at here
            burst_count <= next_count;
        end
    end

    // stage one: the command registered on this edge
    pss_ctl_t s1_ctl;
    logic [ADDR_W-1:0] s1_addr;
    logic [LANES-1:0] s1_lane_n;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s1_ctl <= '0;
        end else if (load) begin
            s1_ctl.valid <= selected;
            s1_ctl.write <= !rw_select_in;
        end else if (advance) begin
            s1_ctl <= burst_ctl;
        end
    end

    always_ff @(posedge clk_in) begin
        if (load) begin
            s1_addr <= ext_addr;
        end else if (advance) begin
            s1_addr <= {burst_base[ADDR_W-1:BW],
                        beat_low(burst_base[BW-1:0], next_count, order)};
        end
    end

    // lane enables are taken on every active edge, load or advance
    always_ff @(posedge clk_in) begin
        if (step) begin
            s1_lane_n <= lane_write_n_in;
        end
    end

    // stage two: the slot whose data moves on the next active edge
    pss_ctl_t s2_ctl;
    logic [ADDR_W-1:0] s2_addr;
    logic [LANES-1:0] s2_lane_n;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s2_ctl <= '0;
        end else if (step) begin
            s2_ctl <= s1_ctl;
        end
    end

    always_ff @(posedge clk_in) begin
        if (step) begin
            s2_addr <= s1_addr;
            s2_lane_n <= s1_lane_n;
        end
    end

    logic rd_en;
    logic wr_en;
    logic [LANES-1:0] wr_lane;
    logic [DATA_W-1:0] rd_data;

    // the read starts one edge early so data is out two edges after the load
    assign rd_en = step && s1_ctl.valid && !s1_ctl.write;
    // write data arrives two edges after its address, with no bus turnaround gap
    assign wr_en = step && s2_ctl.valid && s2_ctl.write;
    assign wr_lane = ~s2_lane_n;

    // parity columns exist only when PARITY is set, so 32-bit carries none
    pss_array #(
        .ADDR_W(ADDR_W),
        .LANES(LANES),
        .LANE_W(LANE_W)
    ) u_array (
        .clk_in(clk_in),
        .rd_en_in(rd_en),
        .rd_addr_in(s1_addr),
        .rd_data_out(rd_data),
        .wr_en_in(wr_en),
        .wr_addr_in(s2_addr),
        .wr_lane_in(wr_lane),
        .wr_data_in(data_lane_in)
    );

    // output slot: registered read data and whether this slot drives the bus
    logic out_valid;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            out_valid <= 1'b0;
        end else if (step) begin
            out_valid <= s2_ctl.valid && !s2_ctl.write;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            data_lane_out <= '0;
        end else if (step && s2_ctl.valid && !s2_ctl.write) begin
            data_lane_out <= rd_data;
        end
    end

    // output enable acts at once and leaves the pipeline untouched;
    // snooze also turns the drivers off so a sleeping port never fights the bus
    assign data_lane_oe_out = out_valid && !output_enable_n_in && !asleep;
endmodule

// ### sim/pipelined_sync_sram_port_test.sv
// self-checking bench for the pipelined memory port
`timescale 1ns/1ps
`define CHK(g, e) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
    end \
end
module pipelined_sync_sram_port_test;
    localparam int AW = 6;
    localparam int DW = 36;
    typedef struct {int k; int a; logic [3:0] ln;} pss_ent_t;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic oe_n = 1'b0;
    logic sleep = 1'b0;
    logic order_n = 1'b0;
    wire logic cke_n, adv, rw, oe, asleep;
    wire logic [2:0] sel_n;
    wire logic [AW-1:0] addr;
    wire logic [3:0] lanes_n;
    wire logic [DW-1:0] din, dout;
    logic [DW-1:0] mem [int];
    pss_ent_t q[$];
    int bk, ba, bn, err_total, checks_done;
    int seed = 90535;
    always #2 clk_in = ~clk_in;
    pss_host_model #(.AW(AW), .DW(DW)) host (.clk_in, .cke_n_out(cke_n), .adv_out(adv),
        .rw_out(rw), .sel_n_out(sel_n), .addr_out(addr), .lanes_n_out(lanes_n), .wdata_out(din));
    pss_port #(.ADDR_W(AW), .LANES(4), .PARITY(1)) dut (.clk_in, .srst_in,
        .clock_enable_n_in(cke_n), .advance_or_load_in(adv), .rw_select_in(rw),
        .select_low_first_n_in(sel_n[0]), .select_low_second_n_in(sel_n[1]),
        .select_high_in(!sel_n[2]), .address_bit_zero_in(addr[0]), .address_bit_one_in(addr[1]),
        .upper_address_bus_in(addr[AW-1:2]), .lane_write_n_in(lanes_n),
        .linear_order_n_in(order_n), .output_enable_n_in(oe_n), .sleep_request_in(sleep),
        .data_lane_in(din), .data_lane_out(dout), .data_lane_oe_out(oe), .asleep_out(asleep));
    // reference: an entry is due two taken edges after its command
    always @(posedge clk_in) begin
        pss_ent_t e;
        pss_ent_t h;
        if (srst_in || asleep || sleep) begin
            q.delete();
        end else if (!cke_n) begin
            if (!adv) begin
                bk = (sel_n == 3'b000) ? (rw ? 1 : 2) : 0;
                ba = addr;
                bn = 0;
            end else begin
                bn++;
            end
            e.k = bk;
            e.a = order_n ? (ba ^ (bn & 3)) : ((ba & ~3) | ((ba + bn) & 3));
            e.ln = lanes_n;
            q.push_back(e);
            if (q.size() == 3) begin
                h = q.pop_front();
                for (int i = 0; i < 4; i++)
                    if (h.k == 2 && !h.ln[i]) mem[h.a][i*9 +: 9] = din[i*9 +: 9];
                #1;
                `CHK(oe, h.k == 1 && !oe_n)
                if (h.k == 1) `CHK(dout, mem[h.a])
            end
        end
    end
    task automatic beat(input logic v, r, c, input logic [2:0] s, input int a, logic [3:0] l);
        host.issue(v, r, c, s, AW'(a), l, DW'({$random(seed), $random(seed)}));
    endtask
    task automatic idle(input int n);
        repeat (n) beat(0, 0, 0, 3'b111, 0, 4'hF);
    endtask
    task automatic do_reset;
        srst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
    endtask
    task automatic readback;
        oe_n <= 1'b0;
        for (int a = 0; a < 64; a++) beat(0, 1, 0, 3'b000, a, 4'hF);
        idle(3);
    endtask
    // stalls, deselects, bursts and lane masks mixed at random
    task automatic rand_run(input int n);
        repeat (n) begin
            beat(1'($random(seed) % 3 == 0), 1'($random(seed)), 1'($random(seed) % 6 == 0),
                ($random(seed) % 5 == 0) ? 3'($random(seed)) : 3'b000, $random(seed),
                4'($random(seed)));
            oe_n <= 1'($random(seed) % 8 == 0);
        end
        idle(3);
    endtask
    task automatic close_out;
        $display("checks=%0d errors=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        do_reset();
        for (int a = 0; a < 64; a++) beat(0, 0, 0, 3'b000, a, 4'h0);
        readback();
        $display("fill test done");
        rand_run(400);
        $display("linear test done");
        // order select only moves while reset holds the port
        order_n <= 1'b1;
        do_reset();
        rand_run(400);
        readback();
        $display("interleaved test done");
        sleep <= 1'b1;
        idle(6);
        #1;
        `CHK(asleep, 1'b1)
        rand_run(20);
        sleep <= 1'b0;
        idle(8);
        #1;
        `CHK(asleep, 1'b0)
        readback();
        $display("snooze test done");
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        close_out();
    end
endmodule

// ### sim/pss_host_model.sv
// host controller model driving the port's command and write data bus
`timescale 1ns/1ps
module pss_host_model #(
    parameter int AW = 6,
    parameter int DW = 36
) (
    input wire logic clk_in,
    output logic cke_n_out,
    output logic adv_out,
    output logic rw_out,
    output logic [2:0] sel_n_out,
    output logic [AW-1:0] addr_out,
    output logic [3:0] lanes_n_out,
    output logic [DW-1:0] wdata_out
);
    logic [DW-1:0] wcur;
    logic [DW-1:0] d1;
    logic rd_mode;
    initial begin
        {cke_n_out, adv_out, rw_out, sel_n_out, addr_out} = '0;
        {lanes_n_out, wdata_out, wcur, d1, rd_mode} = '0;
    end
    task automatic issue(input logic v, r, c, input logic [2:0] s,
            input logic [AW-1:0] a, input logic [3:0] l, input logic [DW-1:0] d);
        @(posedge clk_in);
        cke_n_out <= c;
        adv_out <= v;
        rw_out <= r;
        sel_n_out <= s;
        addr_out <= a;
        // advance beats keep the direction of the last taken load
        if (!c && !v) rd_mode = r;
        lanes_n_out <= (v ? rd_mode : r) ? 4'hF : l;
        wcur <= d;
    endtask
    // data trails its command by two taken edges; outside writes it is a changing pattern
    always @(posedge clk_in) begin
        if (!cke_n_out) begin
            d1 <= wcur;
            wdata_out <= d1;
        end
    end
endmodule

// ### sim/pss_port_monitor.sv
// assertion checker for the pipelined memory port, bound to pss_port
`timescale 1ns/1ps
module pss_port_monitor #(
    parameter int ADDR_W = 18,
    parameter int LANES = 4,
    parameter int PARITY = 1
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic clock_enable_n_in,
    input wire logic advance_or_load_in,
    input wire logic rw_select_in,
    input wire logic select_low_first_n_in,
    input wire logic select_low_second_n_in,
    input wire logic select_high_in,
    input wire logic output_enable_n_in,
    input wire logic sleep_request_in,
    input wire logic [LANES*(8+PARITY)-1:0] data_lane_out,
    input wire logic data_lane_oe_out,
    input wire logic asleep_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    // frozen or sleeping edges do not move a command along
    wire logic act = !clock_enable_n_in && !asleep_out;
    wire logic ld = act && !advance_or_load_in;
    wire logic sel = !select_low_first_n_in && !select_low_second_n_in && select_high_in;
    a_read_drives: assert property (
        ld && sel && rw_select_in ##1 act ##1 act |=> output_enable_n_in || data_lane_oe_out)
        else $error("read slot left undriven");
    a_desel_quiet: assert property (ld && !sel ##1 act ##1 act |=> !data_lane_oe_out)
        else $error("deselect slot drove the bus");
    a_write_quiet: assert property (
        ld && sel && !rw_select_in ##1 act ##1 act |=> !data_lane_oe_out)
        else $error("write slot drove the bus");
    a_freeze_data: assert property (clock_enable_n_in |=> $stable(data_lane_out))
        else $error("data moved on a frozen edge");
    a_oe_gate: assert property (output_enable_n_in |-> !data_lane_oe_out)
        else $error("bus driven with output enable off");
    a_sleep_mute: assert property (asleep_out |-> !data_lane_oe_out)
        else $error("bus driven while asleep");
    a_sleep_entry: assert property (sleep_request_in [*5] |-> asleep_out)
        else $error("snooze not entered");
    a_sleep_exit: assert property (!sleep_request_in [*5] |-> !asleep_out)
        else $error("snooze not left");
    c_read: cover property (ld && sel && rw_select_in ##3 data_lane_oe_out);
    c_desel: cover property (ld && !sel);
    c_sleep: cover property ($rose(asleep_out));
endmodule
bind pss_port pss_port_monitor #(.ADDR_W(ADDR_W), .LANES(LANES), .PARITY(PARITY)) mon (
    .clk_in, .srst_in, .clock_enable_n_in, .advance_or_load_in, .rw_select_in,
    .select_low_first_n_in, .select_low_second_n_in, .select_high_in, .output_enable_n_in,
    .sleep_request_in, .data_lane_out, .data_lane_oe_out, .asleep_out);
